// ### hdl/sensor_i2c_pkg.sv
`default_nettype none
package sensor_i2c_pkg;
  // Clock and timing figures
  localparam int CLK_FREQ_MHZ = 100;
  localparam int POWER_UP_SETTLE_TIME_US = 240;
  localparam int POWER_UP_SETTLE_TYP_US = 180;
  localparam int SOFT_RESET_TIME_US = 240;
  localparam int CONVERSION_BUSY_TIME_US = 12100;
  localparam int SCL_MAX_FREQ_KHZ = 1000;
  // Longest times scale exactly to whole cycles
  localparam int PU_SETTLE_CYCLES = POWER_UP_SETTLE_TIME_US * CLK_FREQ_MHZ;
  localparam int SR_SETTLE_CYCLES = SOFT_RESET_TIME_US * CLK_FREQ_MHZ;
  localparam int CONV_BUSY_CYCLES = CONVERSION_BUSY_TIME_US * CLK_FREQ_MHZ;
  localparam int CNT_W = 22;
  // Bus addressing and commands
  localparam logic [6:0] TARGET_ADDR = 7'h70;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h805D;
  localparam logic [15:0] CMD_NS_T = 16'h7CA2;
  localparam logic [15:0] CMD_NS_H = 16'h5C24;
  localparam logic [15:0] CMD_NN_T = 16'h7866;
  localparam logic [15:0] CMD_NN_H = 16'h58E0;
  localparam logic [15:0] CMD_LS_T = 16'h6458;
  localparam logic [15:0] CMD_LS_H = 16'h44DE;
  localparam logic [15:0] CMD_LN_T = 16'h609C;
  localparam logic [15:0] CMD_LN_H = 16'h401A;
  // Checksum and framing
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_BYTE = 3'h5;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_RX = 4'h3,
    ST_RX_ACK = 4'h4,
    ST_STRETCH = 4'h5,
    ST_TX = 4'h6,
    ST_TX_ACK = 4'h7,
    ST_SKIP = 4'h8
  } bus_state_e;

  typedef struct packed {
    logic [15:0] hum;
    logic [15:0] temp;
  } meas_s;
endpackage
`default_nettype wire

// ### hdl/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### hdl/sensor_i2c_target.sv
// Overview of operation
// - After power-on, reach idle within 240 us; typically 180 us.
// - After soft reset acknowledge, return to idle within 240 us.
// - One combined humidity and temperature conversion finishes within 12.1 ms.
// - During stretching-enabled operation, device may hold clock low until done.
// - Respond only to seven-bit target address 70 hex.
// - While converting, leave write headers, and read headers of non-stretching conversions, unacknowledged.
// - Stretching conversion: acknowledge read, hold clock low, then send results.
// - Soft reset code 805D hex, sent while idle, resets state.
`default_nettype none
module sensor_i2c_target
  import sensor_i2c_pkg::*;
#(
  parameter int PU_CYCLES = sensor_i2c_pkg::PU_SETTLE_CYCLES,
  parameter int SR_CYCLES = sensor_i2c_pkg::SR_SETTLE_CYCLES,
  parameter int MEAS_CYCLES = sensor_i2c_pkg::CONV_BUSY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire sensor_i2c_pkg::meas_s result,
  output logic conv_busy,
  output logic settling
);
  import sensor_i2c_pkg::*;

  bus_state_e state_reg;
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] shift_reg, cmd_hi_reg, tx_data;
  logic [3:0] bit_cnt_reg;
  logic [2:0] byte_idx_reg;
  logic rw_reg, rx_second_reg, soft_rst_hit_reg, meas_start_reg;
  logic stretch_sel_reg, t_first_sel_reg;
  logic sda_oe_n_reg, scl_oe_n_reg, scl_out_reg, sda_out_reg;
  logic settling_reg, settle_sr_reg, conv_busy_reg;
  logic [CNT_W-1:0] settle_cnt_reg, conv_cnt_reg;
  meas_s result_reg;
  logic [15:0] first_word, second_word;

  // Checksum over one data word
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Bus pins into the clock domain; edges well inside a 1 MHz bit
  pin_sync #(.W(2), .RESET_VAL(SYNC_RESET)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Edge and bus condition history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // Readout byte selection in the chosen order
  assign first_word = t_first_sel_reg ? result_reg.temp : result_reg.hum;
  assign second_word = t_first_sel_reg ? result_reg.hum : result_reg.temp;
  always_comb begin
    unique case (byte_idx_reg)
      3'h0: tx_data = first_word[15:8];
      3'h1: tx_data = first_word[7:0];
      3'h2: tx_data = crc8(first_word);
      3'h3: tx_data = second_word[15:8];
      3'h4: tx_data = second_word[7:0];
      3'h5: tx_data = crc8(second_word);
      default: tx_data = 8'hFF;
    endcase
  end

  // Bus protocol engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cmd_hi_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 3'h0;
      rw_reg <= 1'b0;
      rx_second_reg <= 1'b0;
      soft_rst_hit_reg <= 1'b0;
      meas_start_reg <= 1'b0;
      stretch_sel_reg <= 1'b0;
      t_first_sel_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else begin
      soft_rst_hit_reg <= 1'b0;
      meas_start_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_n_reg <= 1'b1;
        scl_oe_n_reg <= 1'b1;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
        scl_oe_n_reg <= 1'b1;
      end else begin
        unique case (state_reg)
          ST_IDLE, ST_SKIP: begin
            sda_oe_n_reg <= 1'b1;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
              if (shift_reg[7:1] == TARGET_ADDR && !settling_reg &&
                  (!conv_busy_reg || (shift_reg[0] && stretch_sel_reg))) begin
                state_reg <= ST_ADDR_ACK;
                sda_oe_n_reg <= 1'b0;
                rw_reg <= shift_reg[0];
                byte_idx_reg <= 3'h0;
                rx_second_reg <= 1'b0;
              end else begin
                state_reg <= ST_SKIP;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (!rw_reg) begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= ST_RX;
              end else if (conv_busy_reg) begin
                sda_oe_n_reg <= 1'b1;
                scl_oe_n_reg <= 1'b0;
                state_reg <= ST_STRETCH;
              end else begin
                shift_reg <= {tx_data[6:0], 1'b1};
                sda_oe_n_reg <= tx_data[7];
                bit_cnt_reg <= 4'h1;
                state_reg <= ST_TX;
              end
            end
          end
          ST_STRETCH: begin
            // Release clock with first bit once results are in
            if (!conv_busy_reg) begin
              shift_reg <= {tx_data[6:0], 1'b1};
              sda_oe_n_reg <= tx_data[7];
              bit_cnt_reg <= 4'h1;
              scl_oe_n_reg <= 1'b1;
              state_reg <= ST_TX;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              sda_oe_n_reg <= shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == BYTE_BITS) begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= ST_TX_ACK;
              end
            end
          end
          ST_TX_ACK: begin
            // Master NACK or last byte ends the readout
            if (scl_rise) begin
              if (sda_s || byte_idx_reg == LAST_BYTE) begin
                state_reg <= ST_SKIP;
              end else begin
                byte_idx_reg <= byte_idx_reg + 3'h1;
              end
            end else if (scl_fall) begin
              shift_reg <= {tx_data[6:0], 1'b1};
              sda_oe_n_reg <= tx_data[7];
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_TX;
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
              sda_oe_n_reg <= 1'b0;
              state_reg <= ST_RX_ACK;
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_n_reg <= 1'b1;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RX;
              rx_second_reg <= ~rx_second_reg;
              if (!rx_second_reg) begin
                cmd_hi_reg <= shift_reg;
              end else if ({cmd_hi_reg, shift_reg} == CMD_SOFT_RESET) begin
                soft_rst_hit_reg <= 1'b1;
                state_reg <= ST_SKIP;
              end else begin
                // Measurement commands pick stretching and order
                case ({cmd_hi_reg, shift_reg})
                  CMD_NS_T, CMD_LS_T: begin
                    meas_start_reg <= 1'b1;
                    stretch_sel_reg <= 1'b1;
                    t_first_sel_reg <= 1'b1;
                  end
                  CMD_NS_H, CMD_LS_H: begin
                    meas_start_reg <= 1'b1;
                    stretch_sel_reg <= 1'b1;
                    t_first_sel_reg <= 1'b0;
                  end
                  CMD_NN_T, CMD_LN_T: begin
                    meas_start_reg <= 1'b1;
                    stretch_sel_reg <= 1'b0;
                    t_first_sel_reg <= 1'b1;
                  end
                  CMD_NN_H, CMD_LN_H: begin
                    meas_start_reg <= 1'b1;
                    stretch_sel_reg <= 1'b0;
                    t_first_sel_reg <= 1'b0;
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Power-up and soft reset settling interval
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settling_reg <= 1'b1;
      settle_sr_reg <= 1'b0;
      settle_cnt_reg <= '0;
    end else if (soft_rst_hit_reg) begin
      settling_reg <= 1'b1;
      settle_sr_reg <= 1'b1;
      settle_cnt_reg <= '0;
    end else if (settling_reg) begin
      if (settle_cnt_reg == (settle_sr_reg ? CNT_W'(SR_CYCLES - 1) : CNT_W'(PU_CYCLES - 1))) begin
        settling_reg <= 1'b0;
      end else begin
        settle_cnt_reg <= settle_cnt_reg + 1'b1;
      end
    end
  end

  // Conversion timer and result capture
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst_hit_reg) begin
      conv_busy_reg <= 1'b0;
      conv_cnt_reg <= '0;
      result_reg <= '0;
    end else if (meas_start_reg) begin
      conv_busy_reg <= 1'b1;
      conv_cnt_reg <= '0;
    end else if (conv_busy_reg) begin
      if (conv_cnt_reg == CNT_W'(MEAS_CYCLES - 1)) begin
        conv_busy_reg <= 1'b0;
        result_reg <= result;
      end else begin
        conv_cnt_reg <= conv_cnt_reg + 1'b1;
      end
    end
  end

  // Open-drain drivers always present a low level
  always_ff @(posedge sys_clk) begin
    scl_out_reg <= 1'b0;
    sda_out_reg <= 1'b0;
  end

  assign scl_out = scl_out_reg;
  assign sda_out = sda_out_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign conv_busy = conv_busy_reg;
  assign settling = settling_reg;

  // Checking helpers: run lengths of the busy outputs
  logic [CNT_W-1:0] settle_age_reg, conv_age_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settle_age_reg <= '0;
      conv_age_reg <= '0;
    end else begin
      settle_age_reg <= settling ? settle_age_reg + 1'b1 : '0;
      conv_age_reg <= conv_busy ? conv_age_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_hold_low;
    !scl_oe_n && conv_busy;
  endsequence
  sequence s_release;
    ##[0:1] scl_oe_n;
  endsequence

  property p_settle_max;
    settle_age_reg <= (settle_sr_reg ? CNT_W'(SR_CYCLES) : CNT_W'(PU_CYCLES));
  endproperty
  a_settle_max: assert property (p_settle_max) else $error("settling too long");
  property p_sr_len;
    $fell(settling) && settle_sr_reg |-> settle_age_reg == CNT_W'(SR_CYCLES);
  endproperty
  a_sr_len: assert property (p_sr_len) else $error("soft reset settle length");
  property p_conv_len;
    $fell(conv_busy) && !$past(soft_rst_hit_reg) |-> conv_age_reg == CNT_W'(MEAS_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_stretch_only;
    !scl_oe_n |-> rw_reg && stretch_sel_reg && state_reg == ST_STRETCH;
  endproperty
  a_stretch_only: assert property (p_stretch_only) else $error("stray clock hold");
  property p_addr_match;
    $rose(state_reg == ST_ADDR_ACK) |-> $past(shift_reg[7:1]) == TARGET_ADDR && !sda_oe_n;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("wrong address acked");
  property p_busy_nack;
    $rose(state_reg == ST_ADDR_ACK) |-> !$past(conv_busy) || (rw_reg && stretch_sel_reg);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("header acked while busy");
  property p_stretch_end;
    s_hold_low ##1 !conv_busy |-> s_release ##0 state_reg == ST_TX;
  endproperty
  a_stretch_end: assert property (p_stretch_end) else $error("clock not released");
  property p_soft_reset;
    soft_rst_hit_reg |=> settling && !conv_busy && settle_age_reg == '0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken");
  property p_settle_nack;
    $rose(state_reg == ST_ADDR_ACK) |-> !$past(settling);
  endproperty
  a_settle_nack: assert property (p_settle_nack) else $error("header acked while settling");
endmodule
`default_nettype wire

// ### tb/i2c_master_model.sv
`default_nettype none
module i2c_master_model (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period in cycles, keeps the bus clock below 1 MHz
  localparam int HALF = 55;
  logic stretched = 1'b0;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Half an SCL period
  task automatic hp();
    repeat (HALF) @(negedge sys_clk);
  endtask
  // Pull SCL low, keep SDA still briefly after the fall
  task automatic fall();
    scl_oe_n = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask
  // Release SCL and wait while the target holds it low
  task automatic rise();
    int n;
    n = 0;
    scl_oe_n = 1'b1;
    @(negedge sys_clk);
    while (scl !== 1'b1 && n < 9000) begin
      stretched = 1'b1;
      n++;
      @(negedge sys_clk);
    end
    hp();
  endtask
  // One bit out, one bit sampled at the end of high time
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n = b;
    hp();
    rise();
    r = sda;
    fall();
  endtask
  task automatic start();
    sda_oe_n = 1'b1;
    hp();
    rise();
    sda_oe_n = 1'b0;
    hp();
    fall();
  endtask
  task automatic stop();
    sda_oe_n = 1'b0;
    hp();
    rise();
    sda_oe_n = 1'b1;
    hp();
  endtask
  // Byte transfer, then acknowledge bit (mack 1 releases SDA)
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(mack, ack);
  endtask
endmodule
`default_nettype wire

// ### tb/sensor_i2c_target_timing_bench.sv
`default_nettype none
module sensor_i2c_target_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_i2c_pkg::*;
  localparam int PU = 3000;
  localparam int SR = 3000;
  localparam int MEAS = 4000;
  logic sys_clk, rst, scl, sda, m_scl_oe_n, m_sda_oe_n;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, conv_busy, settling, ack, a2;
  meas_s result;
  logic [7:0] rx;
  logic [47:0] d;
  logic [31:0] seed = 32'h0000_0013;
  logic [6:0] a;
  logic [15:0] cmds [4] = '{CMD_NS_T, CMD_NS_H, CMD_NN_T, CMD_NN_H};
  int miscompares = 0;
  int comparisons = 0;
  int set_run = 0, bus_run = 0, set_len = 0, bus_len = 0;
  // Open-drain wires with pull-ups
  assign scl = m_scl_oe_n & (scl_oe_n | scl_out);
  assign sda = m_sda_oe_n & (sda_oe_n | sda_out);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  i2c_master_model m (.sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));
  sensor_i2c_target #(.PU_CYCLES(PU), .SR_CYCLES(SR), .MEAS_CYCLES(MEAS)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .result(result),
    .conv_busy(conv_busy), .settling(settling));
  // Lengths of the latest settle and busy intervals
  always @(posedge sys_clk) begin
    set_run <= (rst || settling !== 1'b1) ? 0 : set_run + 1;
    bus_run <= (conv_busy === 1'b1) ? bus_run + 1 : 0;
    if (!rst && settling === 1'b1) set_len <= set_run + 1;
    if (conv_busy === 1'b1) bus_len <= bus_run + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // Six readout bytes in wire order
  function automatic logic [47:0] exp_bytes(input meas_s r, input logic tfirst);
    logic [15:0] w1, w2;
    w1 = tfirst ? r.temp : r.hum;
    w2 = tfirst ? r.hum : r.temp;
    return {w1, crc8(w1), w2, crc8(w2)};
  endfunction
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bare header then stop
  task automatic hdr(input logic [7:0] h, output logic k);
    m.start();
    m.xfer(h, 1'b1, rx, k);
    m.stop();
  endtask
  task automatic cmd(input logic [15:0] c, output logic k);
    m.start();
    m.xfer(8'hE0, 1'b1, rx, k);
    m.xfer(c[15:8], 1'b1, rx, a2);
    m.xfer(c[7:0], 1'b1, rx, a2);
    m.stop();
  endtask
  // Read header and six bytes, last one not acknowledged
  task automatic rd(output logic [47:0] dd, output logic k);
    m.start();
    m.xfer(8'hE1, 1'b1, rx, k);
    for (int i = 0; i < 6 && k === 1'b0; i++) begin
      m.xfer(8'hFF, i == 5, rx, a2);
      dd = {dd[39:0], rx};
    end
    m.stop();
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    while ((settling !== 1'b0 || conv_busy !== 1'b0) && n < 20000) begin
      n++;
      @(negedge sys_clk);
    end
    check("idle_reached", n < 20000, 1'b1);
  endtask
  initial begin
    repeat (95000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    result = '0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    hdr(8'hE0, ack);
    check("hdr_settling", ack, 1'b1);
    idle_wait();
    check("pu_len", set_len <= PU + 2, 1'b1);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      a = (i == 1) ? 7'h70 : (i == 0 || seed[6:0] == 7'h70) ? 7'h71 : seed[6:0];
      hdr({a, 1'b0}, ack);
      check("addr_ack", ack, a != 7'h70);
    end
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      result = seed;
      cmd(cmds[k], ack);
      check("cmd_ack", ack, 1'b0);
      if (k >= 2) begin
        hdr(8'hE0, ack);
        check("busy_wr", ack, 1'b1);
        hdr(8'hE1, ack);
        check("busy_rd", ack, 1'b1);
        idle_wait();
      end
      m.stretched = 1'b0;
      rd(d, ack);
      check("rd_ack", ack, 1'b0);
      check("stretched", m.stretched, k < 2);
      check("bytes", d, exp_bytes(result, !k[0]));
      check("busy_len", bus_len inside {[1:MEAS + 2]}, 1'b1);
    end
    idle_wait();
    cmd(CMD_SOFT_RESET, ack);
    check("sr_ack", ack, 1'b0);
    hdr(8'hE0, ack);
    check("sr_nack", ack, 1'b1);
    check("sr_settling", settling, 1'b1);
    idle_wait();
    check("sr_len", set_len <= SR + 2, 1'b1);
    hdr(8'hE0, ack);
    check("sr_idle", ack, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
